// File: rtl/lcp_pkg.sv
package lcp_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned PAGE_W      = 3;
  localparam int unsigned COL_W       = 6;
  localparam int unsigned ADDR_W      = 9;
  localparam int unsigned LINE_W      = 6;
  localparam int unsigned SEG_N       = 64;
  localparam int unsigned RAM_DEPTH   = 512;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [LINE_W-1:0] START_LINE_RST = 6'h00;
  localparam logic              DISP_ON_RST    = 1'b0;

  // ----------------------------------------------------------------
  // status byte field positions
  // ----------------------------------------------------------------
  localparam int unsigned ST_BUSY_BIT  = 7;
  localparam int unsigned ST_OFF_BIT   = 5;
  localparam int unsigned ST_RESET_BIT = 4;

  // ----------------------------------------------------------------
  // instruction opcodes
  // ----------------------------------------------------------------
  localparam logic [6:0] OP_ONOFF  = 7'h1f;
  localparam logic [1:0] OP_START  = 2'h3;
  localparam logic [4:0] OP_PAGE   = 5'h17;
  localparam logic [1:0] OP_COL    = 2'h1;

  // ----------------------------------------------------------------
  // timing: busy lasts BUSY_PHI operating-clock periods (1..3)
  // ----------------------------------------------------------------
  localparam logic [1:0] BUSY_PHI = 2'h2;

  typedef enum logic [1:0] {
    LCP_OP_WR_INSTR,
    LCP_OP_RD_STATUS,
    LCP_OP_WR_DATA,
    LCP_OP_RD_DATA
  } lcp_op_t;
endpackage : lcp_pkg

// File: rtl/lcp_host_if.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// host-side decoded access, carried from the bus front end to the core
// ------------------------------------------------------------------
interface lcp_host_if;
  import lcp_pkg::*;
  logic       wr_fall;
  logic       rd_fall;
  lcp_op_t    op;
  logic [7:0] wdata;
  logic       drive;
  modport front (output wr_fall, output rd_fall, output op, output wdata, output drive);
  modport core  (input wr_fall, input rd_fall, input op, input wdata, input drive);
endinterface : lcp_host_if

// File: rtl/lcp_bus_front.sv
`timescale 1ns/1ps
module lcp_bus_front
  import lcp_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   rst,
  input  wire logic   select_low_a_n,
  input  wire logic   select_low_b_n,
  input  wire logic   select_high_c,
  input  wire logic   enable,
  input  wire logic   read_not_write,
  input  wire logic   data_select,
  input  wire logic [7:0] host_bus_in,
  lcp_host_if.front   hif
);
  logic       en_q;
  logic [7:0] bus_q;
  logic       chip_sel;

  assign chip_sel = ~select_low_a_n & ~select_low_b_n & select_high_c;

  // ----------------------------------------------------------------
  // strobe edge detect; byte is sampled every cycle so the value held
  // before the fall is the one taken
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      en_q  <= 1'b0;
      bus_q <= 8'h00;
    end else begin
      en_q  <= enable;
      bus_q <= host_bus_in;
    end
  end

  assign hif.op      = lcp_op_t'({data_select, read_not_write});
  assign hif.wdata   = bus_q;
  assign hif.wr_fall = en_q & ~enable & chip_sel & ~read_not_write;
  assign hif.rd_fall = en_q & ~enable & chip_sel & read_not_write;
  assign hif.drive   = enable & chip_sel & read_not_write;
endmodule : lcp_bus_front

// File: rtl/lcp_column_driver.sv
`timescale 1ns/1ps
// Overview of operation
// - write byte is taken at the falling edge of the enable strobe
// - bus driven only during read while enable is high
// - data select high means display data, low means control
// - static direction input mirrors column to segment mapping
// - frame pulse rise presets line counter from start line
// - line clock rise advances line counter and latches RAM row
// - host strobes are sampled on the core clock, not the operating clock, as is display timing
// - segment is on when latched bit is one, off when zero
// - reset clears display enable and start line to zero
// - without all three chip selects nothing is taken
// - bus bit 7 is most significant, bit 0 least
// - written byte staged then copied into RAM internally
// - data read drives output register, reloads and increments at fall
// - output register survives address set, so host does a dummy read
// - select and direction pair picks data read/write, status, instruction
// - while busy only status read is taken; busy on bit 7
// - display off blanks segments without touching RAM
// - display state shown on status bit 5
// - start line written only by its instruction, sets top row
// - address is 3-bit page over 6-bit column, set separately
// - column counter increments on every data access, wraps 63 to 0
// - instruction decode for on/off, start line, page and column
// - status: busy bit 7, off bit 5, reset bit 4, rest zero
// - busy lasts one to three operating-clock periods
module lcp_column_driver
  import lcp_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              reset_n,
  input  wire logic              addr_reverse,
  input  wire logic              phase1,
  input  wire logic              frame_pulse,
  input  wire logic              line_clock,
  input  wire logic              select_low_a_n,
  input  wire logic              select_low_b_n,
  input  wire logic              select_high_c,
  input  wire logic              enable,
  input  wire logic              read_not_write,
  input  wire logic              data_select,
  input  wire logic [7:0]        host_bus_in,
  output logic      [7:0]        host_bus_out,
  output logic                   host_bus_oe,
  output logic      [SEG_N-1:0]  segment_outputs
);
  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [7:0]        ram_q [RAM_DEPTH];
  logic [7:0]        in_reg_q;
  logic              in_pend_q;
  logic [7:0]        out_reg_q;
  logic [PAGE_W-1:0] page_q;
  logic [COL_W-1:0]  col_q;
  logic [LINE_W-1:0] start_line_q;
  logic              disp_on_q;
  logic [LINE_W-1:0] line_cnt_q;
  logic [SEG_N-1:0]  latch_q;
  logic [1:0]        busy_cnt_q;
  logic              busy;
  logic              ph_q;
  logic              ph_rise;
  logic              frm_q;
  logic              cl_q;
  logic              cl_rise;
  logic              frm_rise;
  logic              dev_reset;
  logic              take;
  logic [7:0]        status;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] pend_addr_q;

  lcp_host_if hif ();

  lcp_bus_front u_front (
    .core_clk       (core_clk),
    .rst            (rst),
    .select_low_a_n (select_low_a_n),
    .select_low_b_n (select_low_b_n),
    .select_high_c  (select_high_c),
    .enable         (enable),
    .read_not_write (read_not_write),
    .data_select    (data_select),
    .host_bus_in    (host_bus_in),
    .hif            (hif)
  );

  assign dev_reset = ~reset_n;
  assign cur_addr  = {page_q, col_q};
  assign busy      = (busy_cnt_q != 2'h0) | in_pend_q;
  // a write while busy or in reset is dropped, only status reads pass
  assign take      = hif.wr_fall & ~busy & ~dev_reset;

  // ----------------------------------------------------------------
  // edge detect of display timing and operating clock
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ph_q  <= 1'b0;
      frm_q <= 1'b0;
      cl_q  <= 1'b0;
    end else begin
      ph_q  <= phase1;
      frm_q <= frame_pulse;
      cl_q  <= line_clock;
    end
  end
  assign ph_rise  = phase1 & ~ph_q;
  assign frm_rise = frame_pulse & ~frm_q;
  assign cl_rise  = line_clock & ~cl_q;

  // ----------------------------------------------------------------
  // busy timer counts operating-clock periods, not core cycles
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_cnt_q <= 2'h0;
    end else if (take && hif.op == LCP_OP_WR_INSTR) begin
      busy_cnt_q <= BUSY_PHI;
    end else if (ph_rise && busy_cnt_q != 2'h0) begin
      busy_cnt_q <= busy_cnt_q - 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      disp_on_q    <= DISP_ON_RST;
      start_line_q <= START_LINE_RST;
    end else if (dev_reset) begin
      disp_on_q    <= DISP_ON_RST;
      start_line_q <= START_LINE_RST;
    end else if (take && hif.op == LCP_OP_WR_INSTR) begin
      if (hif.wdata[7:1] == OP_ONOFF) begin
        disp_on_q <= hif.wdata[0];
      end else if (hif.wdata[7:6] == OP_START) begin
        start_line_q <= hif.wdata[5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // address counter; column wraps naturally at 6 bits
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      page_q <= '0;
      col_q  <= '0;
    end else if (take && hif.op == LCP_OP_WR_INSTR) begin
      if (hif.wdata[7:3] == OP_PAGE) begin
        page_q <= hif.wdata[2:0];
      end else if (hif.wdata[7:6] == OP_COL) begin
        col_q <= hif.wdata[5:0];
      end
    end else if ((take && hif.op == LCP_OP_WR_DATA) ||
                 (hif.rd_fall && hif.op == LCP_OP_RD_DATA && !busy && !dev_reset)) begin
      col_q <= col_q + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // input staging: copied to RAM on the next operating-clock edge
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_reg_q    <= 8'h00;
      in_pend_q   <= 1'b0;
      pend_addr_q <= '0;
    end else if (take && hif.op == LCP_OP_WR_DATA) begin
      in_reg_q    <= hif.wdata;
      in_pend_q   <= 1'b1;
      pend_addr_q <= cur_addr;
    end else if (ph_rise) begin
      in_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (in_pend_q && ph_rise) begin
      ram_q[pend_addr_q] <= in_reg_q;
    end
  end

  // ----------------------------------------------------------------
  // output register: reloaded only by a data read, kept otherwise
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_reg_q <= 8'h00;
    end else if (hif.rd_fall && hif.op == LCP_OP_RD_DATA && !busy && !dev_reset) begin
      out_reg_q <= ram_q[cur_addr];
    end
  end

  assign status = {busy, 1'b0, ~disp_on_q, dev_reset, 4'h0};

  always_comb begin
    host_bus_out = 8'h00;
    case (hif.op)
      LCP_OP_RD_STATUS: host_bus_out = status;
      LCP_OP_RD_DATA:   host_bus_out = out_reg_q;
      default:          host_bus_out = 8'h00;
    endcase
  end
  assign host_bus_oe = hif.drive;

  // ----------------------------------------------------------------
  // display side: line counter and row latch
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      line_cnt_q <= '0;
    end else if (frm_rise) begin
      line_cnt_q <= start_line_q;
    end else if (cl_rise) begin
      line_cnt_q <= line_cnt_q + 6'h01;
    end
  end

  // row N sits in bit N%8 of page N/8 across all 64 columns
  for (genvar g = 0; g < SEG_N; g++) begin : g_seg
    logic [COL_W-1:0] col_sel;
    assign col_sel = addr_reverse ? COL_W'(g) : COL_W'(SEG_N - 1 - g);
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        latch_q[g] <= 1'b0;
      end else if (cl_rise) begin
        latch_q[g] <= ram_q[{line_cnt_q[5:3], col_sel}][line_cnt_q[2:0]];
      end
    end
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        segment_outputs[g] <= 1'b0;
      end else begin
        segment_outputs[g] <= latch_q[g] & disp_on_q;
      end
    end
  end
endmodule : lcp_column_driver

// File: tb/lcp_host_model.sv
`timescale 1ns/1ps
module lcp_host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] host_bus_out,
  input  wire logic       host_bus_oe,
  output logic            select_low_a_n,
  output logic            select_low_b_n,
  output logic            select_high_c,
  output logic            enable,
  output logic            read_not_write,
  output logic            data_select,
  output logic      [7:0] host_bus_in,
  output logic            rd_stb,
  output logic      [7:0] rd_data
);
  // ----------------------------------------------------------------
  // host bus cycles
  // ----------------------------------------------------------------
  logic [7:0] hdata = 8'h00;
  logic       drv   = 1'b0;
  // released bus shows the inverse of the last byte, never a held copy
  assign host_bus_in = host_bus_oe ? host_bus_out : (drv ? hdata : ~hdata);
  initial begin
    {select_low_a_n, select_low_b_n, select_high_c, enable} = 4'b1100;
    {read_not_write, data_select, rd_stb, rd_data} = 11'h000;
  end
  task automatic access(input logic rnw, ds, csc, chk, input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk);
    #2;
    {select_low_a_n, select_low_b_n, select_high_c} = {2'b00, csc};
    {read_not_write, data_select, hdata, drv} = {rnw, ds, d, ~rnw};
    enable = 1'b1;
    repeat (2) @(posedge core_clk);
    #2;
    // read byte is taken once the edge has settled, just before the strobe falls
    q = host_bus_in;
    enable = 1'b0;
    rd_data = q;
    rd_stb = chk & rnw;
    @(posedge core_clk);
    #2;
    {drv, rd_stb, select_low_a_n, select_low_b_n, select_high_c} = 5'b00110;
  endtask : access
endmodule : lcp_host_model

// File: tb/lcp_column_driver_checker.sv
`timescale 1ns/1ps
module lcp_column_driver_checker
  import lcp_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             rst,
  input wire logic             reset_n,
  input wire logic             addr_reverse,
  input wire logic             phase1,
  input wire logic             frame_pulse,
  input wire logic             line_clock,
  input wire logic             select_low_a_n,
  input wire logic             select_low_b_n,
  input wire logic             select_high_c,
  input wire logic             enable,
  input wire logic             read_not_write,
  input wire logic             data_select,
  input wire logic [7:0]       host_bus_in,
  input wire logic [7:0]       host_bus_out,
  input wire logic             host_bus_oe,
  input wire logic [SEG_N-1:0] segment_outputs
);
  // ----------------------------------------------------------------
  // bus and display properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic sel;
  logic st;
  assign sel = !select_low_a_n && !select_low_b_n && select_high_c;
  assign st  = host_bus_oe && !data_select;
  a_drive_only_read: assert property (host_bus_oe |-> enable && read_not_write)
    else $error("bus driven outside a read strobe");
  a_select_gates_bus: assert property (!sel |-> !host_bus_oe)
    else $error("bus driven while not selected");
  a_read_drives_bus: assert property (enable && sel && read_not_write |-> host_bus_oe)
    else $error("selected read strobe not driven");
  a_status_zero_bits: assert property (st |-> host_bus_out[6] == 1'b0 && host_bus_out[3:0] == 4'h0)
    else $error("status spare bits not zero");
  a_status_reset_flag: assert property (st && $past(reset_n) == reset_n && $past(reset_n, 3) == reset_n
    |-> host_bus_out[4] == !reset_n)
    else $error("status reset flag wrong");
  a_off_blanks_segs: assert property (st && host_bus_out[5] |-> segment_outputs == '0)
    else $error("segments lit while display off");
  a_outreg_holds: assert property (host_bus_oe && $past(host_bus_oe) && data_select && $past(data_select)
    |-> $stable(host_bus_out))
    else $error("read data moved during strobe");
  a_reset_dark: assert property (!reset_n [*4] |-> segment_outputs == '0)
    else $error("segments lit during device reset");
  c_data_read: cover property (host_bus_oe && data_select);
  c_busy_seen: cover property (st && host_bus_out[7]);
  c_row_lit: cover property ($rose(line_clock) ##[1:4] segment_outputs != '0);
endmodule : lcp_column_driver_checker
bind lcp_column_driver lcp_column_driver_checker u_chk (.core_clk(core_clk), .rst(rst), .reset_n(reset_n),
  .addr_reverse(addr_reverse), .phase1(phase1), .frame_pulse(frame_pulse), .line_clock(line_clock),
  .select_low_a_n(select_low_a_n), .select_low_b_n(select_low_b_n), .select_high_c(select_high_c),
  .enable(enable), .read_not_write(read_not_write), .data_select(data_select), .host_bus_in(host_bus_in),
  .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe), .segment_outputs(segment_outputs));

// File: tb/test_lcp_column_driver.sv
`timescale 1ns/1ps
module test_lcp_column_driver;
  import lcp_pkg::*;
  logic core_clk, rst, reset_n, frame_pulse, line_clock, select_low_a_n, select_low_b_n, select_high_c;
  logic enable, read_not_write, data_select, host_bus_oe, rd_stb;
  logic phase1 = 1'b0;
  logic addr_reverse = 1'b1;
  logic [7:0] host_bus_in, host_bus_out, rd_data, q;
  logic [SEG_N-1:0] segment_outputs;
  logic [7:0] expq[$];
  logic [7:0] wb[3];
  int fails, compares, seed;
  lcp_column_driver u_dut (.core_clk(core_clk), .rst(rst), .reset_n(reset_n), .addr_reverse(addr_reverse),
    .phase1(phase1), .frame_pulse(frame_pulse), .line_clock(line_clock), .select_low_a_n(select_low_a_n),
    .select_low_b_n(select_low_b_n), .select_high_c(select_high_c), .enable(enable),
    .read_not_write(read_not_write), .data_select(data_select), .host_bus_in(host_bus_in),
    .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe), .segment_outputs(segment_outputs));
  lcp_host_model u_host (.core_clk(core_clk), .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe),
    .select_low_a_n(select_low_a_n), .select_low_b_n(select_low_b_n), .select_high_c(select_high_c),
    .enable(enable), .read_not_write(read_not_write), .data_select(data_select),
    .host_bus_in(host_bus_in), .rd_stb(rd_stb), .rd_data(rd_data));
  // ----------------------------------------------------------------
  // clocks, checking and bus helpers
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always begin
    repeat (4) @(posedge core_clk);
    #2 phase1 = ~phase1;
  end
  task automatic check(input logic [63:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic acc(input logic rnw, ds, input logic [7:0] d, input logic chk = 1'b0, csc = 1'b1);
    u_host.access(rnw, ds, csc, chk, d, q);
  endtask : acc
  // polling is bounded so a stuck busy flag ends as a mismatch
  task automatic wait_ready;
    for (int i = 0; i < 40; i++) begin
      acc(1'b1, 1'b0, 8'h00);
      if (q[7] === 1'b0) return;
    end
    fails++;
  endtask : wait_ready
  task automatic instr(input logic [7:0] c);
    acc(1'b0, 1'b0, c);
    wait_ready();
  endtask : instr
  task automatic expect_rd(input logic ds, input logic [7:0] e);
    expq.push_back(e);
    acc(1'b1, ds, 8'h00, 1'b1);
  endtask : expect_rd
  task automatic pulse(ref logic s);
    @(posedge core_clk);
    #2 s = 1'b1;
    repeat (8) @(posedge core_clk);
    #2 s = 1'b0;
    repeat (8) @(posedge core_clk);
  endtask : pulse
  always @(posedge rd_stb) check(rd_data, expq.pop_front());
  initial begin
    #2_000_000;
    fails++;
    conclude();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {seed, fails, compares} = {32'd2430, 64'd0};
    {rst, reset_n, frame_pulse, line_clock} = 4'b1000;
    repeat (20) @(posedge core_clk);
    #2 rst = 1'b0;
    repeat (2) @(posedge core_clk);
    expect_rd(1'b0, 8'h30);
    acc(1'b0, 1'b0, 8'h3f);
    expect_rd(1'b0, 8'h30);
    @(posedge core_clk);
    #2 reset_n = 1'b1;
    repeat (4) @(posedge core_clk);
    expect_rd(1'b0, 8'h20);
    for (int i = 0; i < 3; i++) begin
      wb[i] = $random(seed);
      // neighbouring rows differ so a stuck line counter shows up
      wb[i][1] = ~wb[i][0];
    end
    instr(8'hbd);
    instr(8'h7e);
    acc(1'b0, 1'b0, 8'he8);
    acc(1'b0, 1'b1, 8'h00);
    expect_rd(1'b0, 8'ha0);
    wait_ready();
    acc(1'b0, 1'b1, wb[0]);
    wait_ready();
    acc(1'b0, 1'b1, 8'hff, 1'b0, 1'b0);
    acc(1'b0, 1'b1, wb[1]);
    wait_ready();
    acc(1'b0, 1'b1, wb[2]);
    wait_ready();
    pulse(frame_pulse);
    pulse(line_clock);
    check(segment_outputs, 64'h0);
    instr(8'h3f);
    expect_rd(1'b0, 8'h00);
    repeat (3) @(posedge core_clk);
    check({segment_outputs[62], segment_outputs[63], segment_outputs[0]}, {wb[0][0], wb[1][0], wb[2][0]});
    pulse(line_clock);
    check({segment_outputs[62], segment_outputs[63], segment_outputs[0]}, {wb[0][1], wb[1][1], wb[2][1]});
    @(posedge core_clk);
    #2 addr_reverse = 1'b0;
    pulse(frame_pulse);
    pulse(line_clock);
    check({segment_outputs[1], segment_outputs[0], segment_outputs[63]}, {wb[0][0], wb[1][0], wb[2][0]});
    @(posedge core_clk);
    #2 reset_n = 1'b0;
    repeat (6) @(posedge core_clk);
    check(segment_outputs, 64'h0);
    expect_rd(1'b0, 8'h30);
    @(posedge core_clk);
    #2 reset_n = 1'b1;
    repeat (4) @(posedge core_clk);
    instr(8'h3f);
    repeat (3) @(posedge core_clk);
    check({segment_outputs[1], segment_outputs[0], segment_outputs[63]}, {wb[0][0], wb[1][0], wb[2][0]});
    instr(8'h3e);
    repeat (3) @(posedge core_clk);
    check(segment_outputs, 64'h0);
    instr(8'hbd);
    instr(8'h7e);
    acc(1'b1, 1'b1, 8'h00);
    for (int i = 0; i < 3; i++) expect_rd(1'b1, wb[i]);
    repeat (4) @(posedge core_clk);
    check(expq.size(), 0);
    conclude();
  end
endmodule : test_lcp_column_driver
